// ### common/tcc_pkg.sv
// tcc_pkg: constants, register map and carrier types for the timer
// capture/compare channel block.
// assumes a byte-wide register file reached over a 32-bit wishbone slave.
`default_nettype none
package tcc_pkg;

	// ************************************************************
	// register indexes (byte address = 4 * index)
	// ************************************************************
	localparam logic [7:0] IDX_CHAN0_VALUE_LOW  = 8'hda;
	localparam logic [7:0] IDX_CHAN0_VALUE_HIGH = 8'hdb;
	localparam logic [7:0] IDX_CHAN1_VALUE_LOW  = 8'hdc;
	localparam logic [7:0] IDX_CHAN1_VALUE_HIGH = 8'hdd;
	localparam logic [7:0] IDX_CHAN2_VALUE_LOW  = 8'hde;
	localparam logic [7:0] IDX_CHAN2_VALUE_HIGH = 8'hdf;
	localparam logic [7:0] IDX_CHAN1_CONTROL    = 8'he6;
	localparam logic [7:0] IDX_CHAN2_CONTROL    = 8'he7;
	localparam logic [7:0] IDX_RADIO_MASK       = 8'he8;
	localparam logic [7:0] IDX_IRQ_STATUS       = 8'he9;
	localparam logic [7:0] IDX_IRQ_MASK         = 8'hea;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_VALUE_BYTE = 8'h00;
	localparam logic [7:0] RST_CONTROL    = 8'h40;
	localparam logic [7:0] RST_RADIO_MASK = 8'h00;
	localparam logic [1:0] RST_IRQ_MASK   = 2'h3;

	// ************************************************************
	// field encodings
	// ************************************************************
	localparam logic [2:0] CMP_SET        = 3'h0;
	localparam logic [2:0] CMP_CLEAR      = 3'h1;
	localparam logic [2:0] CMP_TOGGLE     = 3'h2;
	localparam logic [2:0] CMP_SET_UP     = 3'h3;
	localparam logic [2:0] CMP_CLEAR_UP   = 3'h4;
	localparam logic [2:0] CMP_SET_OWN    = 3'h5;
	localparam logic [2:0] CMP_CLEAR_OWN  = 3'h6;
	localparam logic [2:0] CMP_MODULATOR  = 3'h7;
	localparam logic [1:0] CAP_NONE       = 2'h0;
	localparam logic [1:0] CAP_RISE       = 2'h1;
	localparam logic [1:0] CAP_FALL       = 2'h2;
	localparam logic [1:0] CAP_BOTH       = 2'h3;
	localparam int         DATA_DROP_BITS = 2;

	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed {
		logic       capture_source_select;
		logic       channel_irq_mask;
		logic [2:0] compare_action;
		logic       mode;
		logic [1:0] capture_edge_select;
	} tcc_ctl_t;

	typedef struct packed {
		logic        enable;
		logic        speed_quarter;
		logic        interp_en;
		logic        shaping_en;
		logic [15:0] sample_rate;
		logic [13:0] data;
	} tcc_dsm_t;

endpackage
`default_nettype wire

// ### hdl/tcc_channels.sv
// tcc_channels: capture/compare channels 1 and 2 plus the channel 0 value
// of a 16-bit timer, with modulator configuration for channel 1.
// assumes the counter core supplies its value, an update pulse and the
// count direction on clk_sys; capture pins are asynchronous.
//
// How it works
// RULE_01 - source bit 0 picks the capture pin, 1 picks enabled radio events
// RULE_02 - interrupt mask bit 1 enables the channel interrupt; resets to 1
// RULE_03 - on match, action 000 sets, 001 clears, 010 toggles the output
// RULE_04 - 011 sets on up match, clears at zero or on down match
// RULE_05 - 100 clears on up match, sets at zero or on down match
// RULE_06 - 101 sets on own match, clears on channel 0 match
// RULE_07 - 110 clears on own match, sets on channel 0 match; channel 2 ignores 111
// RULE_08 - mode bit 0 means capture, 1 compare, outside modulator mode
// RULE_09 - edge field: 00 none, 01 rising, 10 falling, 11 both edges
// RULE_10 - channel 1 action 111 enables modulator; mode bit picks 1/8 or 1/4
// RULE_11 - modulator edge field sets interpolator and shaping enables
// RULE_12 - in modulator mode channel 0 value sets the sample rate
// RULE_13 - in modulator mode channel 1 value is data, low two bits dropped
// RULE_14 - each 16-bit value is a high and low byte, reset to zero
// RULE_15 - up/down counting gives compare-down matches on the way down
// RULE_16 - a channel flag of 1 means its interrupt is pending
// RULE_17 - a capture copies the counter into the value and sets the flag
// RULE_18 - compares run once per counter update on the full 16-bit value
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module tcc_channels #(
	parameter int CNT_W   = 16,
	parameter int RADIO_W = 8
) (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	// wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [9:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output var  logic [31:0]         wb_dat_o,
	output var  logic                wb_ack_o,
	// counter core
	input  wire logic [CNT_W-1:0]    cnt_value,
	input  wire logic                cnt_tick,
	input  wire logic                cnt_down,
	input  wire logic                cnt_updown,
	// capture sources
	input  wire logic [2:1]          cap_pin,
	input  wire logic [RADIO_W-1:0]  radio_event,
	// outputs
	output var  logic [2:1]          cmp_out,
	output var  tcc_pkg::tcc_dsm_t   dsm_cfg,
	output var  logic                irq
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (CNT_W != 16) begin : g_bad_width
		$error("tcc_channels serves a 16-bit counter only");
	end
	if (RADIO_W < 1 || RADIO_W > 8) begin : g_bad_radio
		$error("tcc_channels radio mask holds 1 to 8 events");
	end

	// ************************************************************
	// register bus
	// ************************************************************
	logic [7:0]         idx;
	logic               take;
	logic               wr;
	logic               rd;
	logic [7:0]         wbyte;
	logic [7:0]         next_rdata;
	logic [15:0]        val0;
	logic [15:0]        val [1:2];
	tcc_pkg::tcc_ctl_t  ctl [1:2];
	logic [7:0]         radio_mask;
	logic [1:0]         irq_status;
	logic [1:0]         irq_mask;
	logic [1:0]         flag_set;
	logic               dsm_on;

	assign idx   = wb_adr_i[9:2];
	assign take  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr    = take & wb_we_i & wb_sel_i[0];
	assign rd    = take & ~wb_we_i;
	assign wbyte = wb_dat_i[7:0];
	assign dsm_on = ctl[1].compare_action == tcc_pkg::CMP_MODULATOR;

	// one wait state: ack follows the taking edge, dropped the cycle after
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= take;
		end
	end

	// read mux; unmapped indexes read zero
	always_comb begin
		next_rdata = 8'h00;
		unique case (idx)
			tcc_pkg::IDX_CHAN0_VALUE_LOW:  next_rdata = val0[7:0]; // RULE_14
			tcc_pkg::IDX_CHAN0_VALUE_HIGH: next_rdata = val0[15:8];
			tcc_pkg::IDX_CHAN1_VALUE_LOW:  next_rdata = val[1][7:0];
			tcc_pkg::IDX_CHAN1_VALUE_HIGH: next_rdata = val[1][15:8];
			tcc_pkg::IDX_CHAN2_VALUE_LOW:  next_rdata = val[2][7:0];
			tcc_pkg::IDX_CHAN2_VALUE_HIGH: next_rdata = val[2][15:8];
			tcc_pkg::IDX_CHAN1_CONTROL:    next_rdata = ctl[1];
			tcc_pkg::IDX_CHAN2_CONTROL:    next_rdata = ctl[2];
			tcc_pkg::IDX_RADIO_MASK:       next_rdata = radio_mask;
			tcc_pkg::IDX_IRQ_STATUS:       next_rdata = {6'h00, irq_status};
			tcc_pkg::IDX_IRQ_MASK:         next_rdata = {6'h00, irq_mask};
			default:                       next_rdata = 8'h00;
		endcase
	end

	// read data registered so it stands with ack
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			wb_dat_o <= {24'h00_0000, next_rdata};
		end
	end

	// channel 0 value, also the modulator sample rate
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			val0 <= {tcc_pkg::RST_VALUE_BYTE, tcc_pkg::RST_VALUE_BYTE};
		end else if (wr && idx == tcc_pkg::IDX_CHAN0_VALUE_LOW) begin
			val0[7:0] <= wbyte; // RULE_14
		end else if (wr && idx == tcc_pkg::IDX_CHAN0_VALUE_HIGH) begin
			val0[15:8] <= wbyte;
		end
	end

	// radio event mask and interrupt mask
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			radio_mask <= tcc_pkg::RST_RADIO_MASK;
			irq_mask   <= tcc_pkg::RST_IRQ_MASK;
		end else begin
			if (wr && idx == tcc_pkg::IDX_RADIO_MASK) begin
				radio_mask <= wbyte;
			end
			if (wr && idx == tcc_pkg::IDX_IRQ_MASK) begin
				irq_mask <= wbyte[1:0];
			end
		end
	end

	// sticky flags, cleared by a read; a new event beats the clear
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_status <= 2'h0;
		end else if (rd && idx == tcc_pkg::IDX_IRQ_STATUS) begin
			irq_status <= flag_set; // RULE_16
		end else begin
			irq_status <= irq_status | flag_set;
		end
	end

	// level interrupt: status gated by both masks
	assign irq = |(irq_status & irq_mask & {ctl[2].channel_irq_mask, ctl[1].channel_irq_mask}); // RULE_02

	// ************************************************************
	// shared compare terms
	// ************************************************************
	logic match0;
	logic at_zero;

	assign match0  = cnt_tick & (cnt_value == val0); // RULE_18
	assign at_zero = cnt_tick & (cnt_value == 16'h0000);

	// ************************************************************
	// per-channel logic
	// ************************************************************
	for (genvar c = 1; c <= 2; c++) begin : g_ch
		logic [2:0]  sync;
		logic        lvl;
		logic        lvl_d;
		logic        edge_hit;
		logic        radio_hit;
		logic        cap_ev;
		logic        cap_mode;
		logic        cmp_mode;
		logic        hit;
		logic        hit_up;
		logic        hit_dn;
		logic        next_out;
		logic [7:0]  rmask;
		logic        modulate;

		assign modulate = (c == 1) && dsm_on;
		assign rmask    = radio_mask & 8'((1 << RADIO_W) - 1);

		// three-stage synchroniser; level moves once stages two and three agree
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				sync  <= 3'h0;
				lvl   <= 1'b0;
				lvl_d <= 1'b0;
			end else begin
				sync  <= {sync[1:0], cap_pin[c]};
				lvl_d <= lvl;
				if (sync[1] == sync[2]) begin
					lvl <= sync[2];
				end
			end
		end

		// edge qualification per edge field
		always_comb begin
			edge_hit = 1'b0;
			unique case (ctl[c].capture_edge_select) // RULE_09
				tcc_pkg::CAP_NONE: edge_hit = 1'b0;
				tcc_pkg::CAP_RISE: edge_hit = lvl & ~lvl_d;
				tcc_pkg::CAP_FALL: edge_hit = ~lvl & lvl_d;
				tcc_pkg::CAP_BOTH: edge_hit = lvl ^ lvl_d;
			endcase
		end

		// radio events bypass the edge logic: they are already pulses
		assign radio_hit = |(radio_event & rmask[RADIO_W-1:0]);
		assign cap_mode  = !modulate && !ctl[c].mode; // RULE_08
		assign cmp_mode  = !modulate && ctl[c].mode;
		assign cap_ev    = cap_mode && (ctl[c].capture_source_select ? // RULE_01
			(radio_hit && ctl[c].capture_edge_select != tcc_pkg::CAP_NONE) : edge_hit);

		// compare terms sampled only on a counter update
		assign hit    = cnt_tick & (cnt_value == val[c]); // RULE_18
		assign hit_up = hit & ~(cnt_updown & cnt_down);
		assign hit_dn = hit & cnt_updown & cnt_down; // RULE_15

		assign flag_set[c-1] = cap_ev | (cmp_mode & hit); // RULE_17

		// control register
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				ctl[c] <= tcc_pkg::RST_CONTROL; // RULE_02
			end else if (wr && idx == (c == 1 ? tcc_pkg::IDX_CHAN1_CONTROL : tcc_pkg::IDX_CHAN2_CONTROL)) begin
				ctl[c] <= wbyte;
			end
		end

		// value register: a capture wins over a same-cycle bus write
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				val[c] <= {tcc_pkg::RST_VALUE_BYTE, tcc_pkg::RST_VALUE_BYTE}; // RULE_14
			end else if (cap_ev) begin
				val[c] <= cnt_value; // RULE_17
			end else if (wr && idx == tcc_pkg::IDX_CHAN1_VALUE_LOW + 8'(2 * (c - 1))) begin
				val[c][7:0] <= wbyte;
			end else if (wr && idx == tcc_pkg::IDX_CHAN1_VALUE_HIGH + 8'(2 * (c - 1))) begin
				val[c][15:8] <= wbyte;
			end
		end

		// output action; a match wins over the zero event in the same update
		always_comb begin
			next_out = cmp_out[c];
			unique case (ctl[c].compare_action)
				tcc_pkg::CMP_SET: if (hit) next_out = 1'b1; // RULE_03
				tcc_pkg::CMP_CLEAR: if (hit) next_out = 1'b0;
				tcc_pkg::CMP_TOGGLE: if (hit) next_out = ~cmp_out[c];
				tcc_pkg::CMP_SET_UP: begin
					if (hit_up) next_out = 1'b1; // RULE_04
					else if (cnt_updown ? hit_dn : at_zero) next_out = 1'b0;
				end
				tcc_pkg::CMP_CLEAR_UP: begin
					if (hit_up) next_out = 1'b0; // RULE_05
					else if (cnt_updown ? hit_dn : at_zero) next_out = 1'b1;
				end
				tcc_pkg::CMP_SET_OWN: begin
					if (hit) next_out = 1'b1; // RULE_06
					else if (match0) next_out = 1'b0;
				end
				tcc_pkg::CMP_CLEAR_OWN: begin
					if (hit) next_out = 1'b0; // RULE_07
					else if (match0) next_out = 1'b1;
				end
				tcc_pkg::CMP_MODULATOR: next_out = cmp_out[c]; // RULE_07
			endcase
		end

		// output only moves in compare mode
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				cmp_out[c] <= 1'b0;
			end else if (cmp_mode) begin
				cmp_out[c] <= next_out;
			end
		end
	end

	// ************************************************************
	// modulator configuration
	// ************************************************************
	// registered so downstream sees a clean word, one cycle behind writes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dsm_cfg <= '0;
		end else begin
			dsm_cfg.enable        <= dsm_on; // RULE_10
			dsm_cfg.speed_quarter <= ctl[1].mode;
			dsm_cfg.interp_en     <= dsm_on & ~ctl[1].capture_edge_select[1]; // RULE_11
			dsm_cfg.shaping_en    <= dsm_on & ~ctl[1].capture_edge_select[0];
			dsm_cfg.sample_rate   <= val0; // RULE_12
			dsm_cfg.data          <= val[1][15:tcc_pkg::DATA_DROP_BITS]; // RULE_13
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) // RULE_14
		else $error("ack held more than one cycle");
	cap_copies_a: assert property (g_ch[1].cap_ev |=> val[1] == $past(cnt_value)) // RULE_17
		else $error("capture did not copy the counter");
	cap_flags_a: assert property (g_ch[2].cap_ev |=> irq_status[1]) // RULE_16
		else $error("capture did not set the flag");
	set_on_match_a: assert property (g_ch[1].cmp_mode && ctl[1].compare_action == tcc_pkg::CMP_SET
		&& g_ch[1].hit |=> cmp_out[1]) // RULE_03
		else $error("set action missed");
	toggle_a: assert property (g_ch[2].cmp_mode && ctl[2].compare_action == tcc_pkg::CMP_TOGGLE
		&& g_ch[2].hit |=> cmp_out[2] != $past(cmp_out[2])) // RULE_03
		else $error("toggle action missed");
	clear_own_a: assert property (g_ch[1].cmp_mode && ctl[1].compare_action == tcc_pkg::CMP_CLEAR_OWN
		&& !g_ch[1].hit && match0 |=> cmp_out[1]) // RULE_07
		else $error("channel 0 match did not set");
	updown_clear_a: assert property (g_ch[2].cmp_mode && ctl[2].compare_action == tcc_pkg::CMP_SET_UP
		&& cnt_updown && g_ch[2].hit_dn |=> !cmp_out[2]) // RULE_04
		else $error("compare-down did not clear");
	zero_set_a: assert property (g_ch[1].cmp_mode && ctl[1].compare_action == tcc_pkg::CMP_CLEAR_UP
		&& !cnt_updown && at_zero && !g_ch[1].hit |=> cmp_out[1]) // RULE_05
		else $error("zero did not set");
	no_cap_none_a: assert property (!ctl[2].capture_source_select
		&& ctl[2].capture_edge_select == tcc_pkg::CAP_NONE |-> !g_ch[2].cap_ev) // RULE_09
		else $error("capture with no edge selected");
	dsm_data_a: assert property (dsm_on |=> dsm_cfg.enable && dsm_cfg.data == $past(val[1][15:2])) // RULE_13
		else $error("modulator data wrong");
	irq_mask_a: assert property (irq_status[0] && !ctl[1].channel_irq_mask && !irq_status[1] |-> !irq) // RULE_02
		else $error("masked channel raised irq");

	// bus answer, flag clearing, interrupt level, set on up match and modes that must stay quiet
	ack_follows_a: assert property (take |=> wb_ack_o) // RULE_14
		else $error("request not acknowledged");
	read_clears_a: assert property (rd && idx == tcc_pkg::IDX_IRQ_STATUS
		&& !flag_set[0] |=> !irq_status[0]) // RULE_16
		else $error("status read did not clear");
	irq_level_a: assert property (irq_status[1] && irq_mask[1] && ctl[2].channel_irq_mask |-> irq) // RULE_02
		else $error("unmasked flag did not raise irq");
	dsm_hold_a: assert property (g_ch[1].modulate |=> cmp_out[1] == $past(cmp_out[1])) // RULE_10
		else $error("output moved in modulator mode");
	radio_off_a: assert property (ctl[2].capture_source_select && !g_ch[2].radio_hit |-> !g_ch[2].cap_ev) // RULE_01
		else $error("capture without enabled radio event");
	set_up_match_a: assert property (g_ch[1].cmp_mode && ctl[1].compare_action == tcc_pkg::CMP_SET_UP
		&& g_ch[1].hit_up |=> cmp_out[1]) // RULE_04
		else $error("up match did not set");

	capture_seen_c: cover property (g_ch[1].cap_ev ##1 irq);
	modulator_c: cover property (dsm_cfg.enable && dsm_cfg.speed_quarter);
	read_clear_c: cover property (rd && idx == tcc_pkg::IDX_IRQ_STATUS && |irq_status);
	toggle_c: cover property (g_ch[2].cmp_mode && ctl[2].compare_action == tcc_pkg::CMP_TOGGLE && g_ch[2].hit);
	radio_capture_c: cover property (g_ch[2].cap_ev && ctl[2].capture_source_select);

endmodule
`default_nettype wire

// ### test/tcc_far_side.sv
// tcc_far_side: counter core, capture pins and radio event sources
// seen by the channels; the bench steers it through its tasks.
`timescale 1ns/1ps
`default_nettype none
module tcc_far_side (
	// clock
	input  wire logic        clk_sys,
	// counter core
	output var  logic [15:0] cnt_value,
	output var  logic        cnt_tick,
	output var  logic        cnt_down,
	output var  logic        cnt_updown,
	// capture sources
	output var  logic [2:1]  cap_pin,
	output var  logic [7:0]  radio_event
);
	// ************
	// stimulus
	// ************
	// quiet levels from time zero
	initial begin
		cnt_value = 16'h0000;
		cnt_tick = 1'b0;
		cnt_down = 1'b0;
		cnt_updown = 1'b0;
		cap_pin = 2'b00;
		radio_event = 8'h00;
	end
	// one update; the count then holds, as a paused core would
	task automatic tick(input logic [15:0] v, input logic dn, input logic ud);
		@(posedge clk_sys);
		cnt_value <= v;
		cnt_tick <= 1'b1;
		cnt_down <= dn;
		cnt_updown <= ud;
		@(posedge clk_sys);
		cnt_tick <= 1'b0;
	endtask
	// pins are always driven, so they keep their level
	task automatic pin(input int ch, input logic lvl);
		@(posedge clk_sys);
		if (ch == 1) begin
			cap_pin[1] <= lvl;
		end else begin
			cap_pin[2] <= lvl;
		end
	endtask
	// radio events are single-cycle pulses
	task automatic radio(input logic [7:0] m);
		@(posedge clk_sys);
		radio_event <= m;
		@(posedge clk_sys);
		radio_event <= 8'h00;
	endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// tb: self-checking bench for the capture/compare channels.
// assumes tcc_pkg, tcc_channels and tcc_far_side compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ************
	// signals
	// ************
	logic              clk_sys;
	logic              resetn;
	logic              wb_cyc_i;
	logic              wb_stb_i;
	logic              wb_we_i;
	logic [9:0]        wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i;
	logic [31:0]       wb_dat_o;
	logic              wb_ack_o;
	logic [15:0]       cnt_value;
	logic              cnt_tick;
	logic              cnt_down;
	logic              cnt_updown;
	logic [2:1]        cap_pin;
	logic [7:0]        radio_event;
	logic [2:1]        cmp_out;
	tcc_pkg::tcc_dsm_t dsm_cfg;
	logic              irq;
	int                n_errors;
	int                n_tests;
	logic [7:0]        rd;
	logic [15:0]       exp_val;
	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;
	tcc_channels DUT (.clk_sys, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .cnt_value, .cnt_tick, .cnt_down, .cnt_updown, .cap_pin, .radio_event,
		.cmp_out, .dsm_cfg, .irq);
	tcc_far_side far (.clk_sys, .cnt_value, .cnt_tick, .cnt_down, .cnt_updown, .cap_pin, .radio_event);
	// ************
	// shared tasks
	// ************
	// counted compare, four-state so unknowns never match
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s seen %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic final_report();
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// classic cycle held until ack is sampled; bounded wait
	task automatic wb(input logic [7:0] idx, input logic we, input logic [7:0] wd);
		int k;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h000000, wd};
		for (k = 0; k < 16; k++) begin
			@(posedge clk_sys);
			if (wb_ack_o === 1'b1) break;
		end
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k == 16) begin
			n_errors++;
			$display("mismatch at %0t: no bus ack", $time);
			final_report();
		end
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		wb(idx, 1'b0, 8'h00);
		check(rd, exp, "read");
	endtask
	// one update, output looked at once it has landed
	task automatic step(input int ch, input logic [15:0] v, input logic dn, input logic ud, input logic exp);
		far.tick(v, dn, ud);
		@(posedge clk_sys);
		check(cmp_out[ch], exp, "out");
	endtask
	// one pin edge on channel 1, then flag, interrupt and value
	task automatic cap_once(input logic lvl, input logic [15:0] cnt, input logic hit, input logic ix);
		far.tick(cnt, 1'b0, 1'b0);
		far.pin(1, lvl);
		repeat (8) @(posedge clk_sys);
		if (hit) exp_val = cnt;
		check(irq, ix, "irq");
		rdchk(8'he9, {7'h00, hit});
		check(irq, 1'b0, "irq");
		rdchk(8'hdc, exp_val[7:0]);
		rdchk(8'hdd, exp_val[15:8]);
	endtask
	// ************
	// scenarios
	// ************
	task automatic sc_reset();
		for (int i = 0; i < 6; i++) rdchk(8'hda + 8'(i), 8'h00);
		rdchk(8'he6, 8'h40);
		rdchk(8'he7, 8'h40);
		rdchk(8'h10, 8'h00);
		wb(8'hdb, 1'b1, 8'ha5);
		wb(8'hda, 1'b1, 8'h3c);
		rdchk(8'hdb, 8'ha5);
		rdchk(8'hda, 8'h3c);
	endtask
	task automatic sc_compare();
		wb(8'hdd, 1'b1, 8'h12);
		wb(8'hdc, 1'b1, 8'h34);
		step(1, 16'h1234, 1'b0, 1'b0, 1'b0);
		wb(8'he6, 1'b1, {2'b01, 3'h0, 1'b1, 2'h0});
		step(1, 16'h1235, 1'b0, 1'b0, 1'b0);
		step(1, 16'h1234, 1'b0, 1'b0, 1'b1);
		rdchk(8'he9, 8'h01);
		rdchk(8'he9, 8'h00);
		wb(8'he6, 1'b1, {2'b01, 3'h1, 1'b1, 2'h0});
		step(1, 16'h0034, 1'b0, 1'b0, 1'b1);
		step(1, 16'h1234, 1'b0, 1'b0, 1'b0);
		wb(8'he6, 1'b1, {2'b01, 3'h2, 1'b1, 2'h0});
		step(1, 16'h1234, 1'b0, 1'b0, 1'b1);
		step(1, 16'h1234, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic sc_updown();
		wb(8'he6, 1'b1, {2'b01, 3'h3, 1'b1, 2'h0});
		step(1, 16'h1234, 1'b0, 1'b0, 1'b1);
		step(1, 16'h0000, 1'b0, 1'b0, 1'b0);
		step(1, 16'h1234, 1'b0, 1'b1, 1'b1);
		step(1, 16'h0000, 1'b1, 1'b1, 1'b1);
		step(1, 16'h1234, 1'b1, 1'b1, 1'b0);
		wb(8'he6, 1'b1, {2'b01, 3'h4, 1'b1, 2'h0});
		step(1, 16'h0000, 1'b0, 1'b0, 1'b1);
		step(1, 16'h1234, 1'b0, 1'b0, 1'b0);
		step(1, 16'h1234, 1'b1, 1'b1, 1'b1);
		wb(8'he9, 1'b0, 8'h00);
	endtask
	task automatic sc_chan2();
		wb(8'hdb, 1'b1, 8'h00);
		wb(8'hda, 1'b1, 8'h30);
		wb(8'hde, 1'b1, 8'h20);
		wb(8'hdf, 1'b1, 8'h00);
		wb(8'he7, 1'b1, {2'b01, 3'h5, 1'b1, 2'h0});
		step(2, 16'h0020, 1'b0, 1'b0, 1'b1);
		step(2, 16'h0030, 1'b0, 1'b0, 1'b0);
		wb(8'he7, 1'b1, {2'b01, 3'h6, 1'b1, 2'h0});
		step(2, 16'h0030, 1'b0, 1'b0, 1'b1);
		step(2, 16'h0020, 1'b0, 1'b0, 1'b0);
		wb(8'he7, 1'b1, {2'b01, 3'h7, 1'b1, 2'h0});
		step(2, 16'h0030, 1'b0, 1'b0, 1'b0);
		wb(8'he7, 1'b1, {2'b01, 3'h2, 1'b1, 2'h0});
		step(2, 16'h0020, 1'b0, 1'b0, 1'b1);
		wb(8'he7, 1'b1, {2'b01, 3'h3, 1'b1, 2'h0});
		step(2, 16'h0020, 1'b1, 1'b1, 1'b0);
		wb(8'he6, 1'b1, {2'b01, 3'h6, 1'b1, 2'h0});
		step(1, 16'h1234, 1'b0, 1'b0, 1'b0);
		step(1, 16'h0030, 1'b0, 1'b0, 1'b1);
		wb(8'he9, 1'b0, 8'h00);
	endtask
	task automatic sc_capture();
		wb(8'hdc, 1'b1, 8'h00);
		wb(8'hdd, 1'b1, 8'h00);
		exp_val = 16'h0000;
		for (int c = 0; c < 4; c++) begin
			wb(8'he6, 1'b1, {2'b01, 3'h0, 1'b0, c[1:0]});
			cap_once(1'b1, 16'h1100 + 16'(c), c[0], c[0]);
			cap_once(1'b0, 16'h2200 + 16'(c), c[1], c[1]);
		end
		wb(8'he6, 1'b1, {2'b01, 3'h0, 1'b1, 2'h3});
		cap_once(1'b1, 16'h3300, 1'b0, 1'b0);
		wb(8'he6, 1'b1, {2'b00, 3'h0, 1'b0, 2'h2});
		cap_once(1'b0, 16'h4400, 1'b1, 1'b0);
	endtask
	task automatic sc_radio();
		wb(8'he8, 1'b1, 8'h04);
		wb(8'he7, 1'b1, {2'b11, 3'h0, 1'b0, 2'h1});
		far.tick(16'h4455, 1'b0, 1'b0);
		far.radio(8'h02);
		far.pin(2, 1'b1);
		repeat (8) @(posedge clk_sys);
		rdchk(8'he9, 8'h00);
		wb(8'hea, 1'b1, 8'h01);
		far.radio(8'h04);
		repeat (8) @(posedge clk_sys);
		check(irq, 1'b0, "irq");
		rdchk(8'he9, 8'h02);
		rdchk(8'hde, 8'h55);
		rdchk(8'hdf, 8'h44);
		wb(8'hea, 1'b1, 8'h03);
	endtask
	task automatic sc_dsm();
		wb(8'hdb, 1'b1, 8'h56);
		wb(8'hda, 1'b1, 8'h78);
		wb(8'hdd, 1'b1, 8'h9a);
		wb(8'hdc, 1'b1, 8'hbf);
		for (int i = 0; i < 8; i++) begin
			wb(8'he6, 1'b1, {2'b01, 3'h7, i[2], i[1:0]});
			repeat (2) @(posedge clk_sys);
			check(dsm_cfg, {1'b1, i[2], ~i[1], ~i[0], 16'h5678, 14'h26af}, "dsm");
		end
		wb(8'he6, 1'b1, 8'h40);
		repeat (2) @(posedge clk_sys);
		check(dsm_cfg.enable, 1'b0, "dsm");
	endtask
	// ************
	// main sequence
	// ************
	initial begin
		clk_sys = 1'b0;
		resetn = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 10'h000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		n_errors = 0;
		n_tests = 0;
		exp_val = 16'h0000;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		sc_reset();
		sc_compare();
		sc_updown();
		sc_chan2();
		sc_capture();
		sc_radio();
		sc_dsm();
		final_report();
	end
endmodule
`default_nettype wire
